// ===== sram_port_pkg.sv
// Constants and carrier types for the static memory controller.
// Assumes a 25 MHz clock; all pin timing is derived from it.
package sram_port_pkg;
  localparam int clk_period_ns = 40;
  localparam int clk_mhz = 25;
  localparam int addr_w = 17;
  localparam int data_w = 16;
  localparam int lane_w = 8;
  // Times in their own units (slower grade figures cover both grades)
  localparam int powerup_wait_us = 1;
  localparam int address_access_delay_ns = 12;
  localparam int address_change_hold_ns = 3;
  localparam int write_data_setup_ns = 6;
  localparam int strobe_output_turnoff_ns = 6;
  localparam int write_pulse_ns = 8;
  localparam int output_enable_access_ns = 8;
  // Cycle counts: least times round up, never below one cycle
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + clk_period_ns - 1) / clk_period_ns;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int powerup_cycles = powerup_wait_us * clk_mhz;
  localparam int read_cycles = ceil_cycles(address_access_delay_ns);
  localparam int write_cycles = ceil_cycles(write_pulse_ns + strobe_output_turnoff_ns
                                             + write_data_setup_ns);
  localparam int cnt_w = 8;
  localparam logic [cnt_w-1:0] cnt_zero = 8'h00;
  localparam logic [cnt_w-1:0] cnt_one = 8'h01;

  typedef struct packed {
    logic write;
    logic [1:0] lanes;
    logic [addr_w-1:0] addr;
    logic [data_w-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic low_lane_enable_n;
    logic high_lane_enable_n;
  } mem_ctl_t;

  localparam mem_ctl_t ctl_idle = 5'h1F;
endpackage

// ===== sram_cycle_timer.sv
// Down counter that times the access phase of each read or write cycle.
// Assumes a single clock and a load pulse from the sequencer.
`timescale 1ns/1ps
module sram_cycle_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [sram_port_pkg::cnt_w-1:0] load_value,
  output logic done
);
  logic [sram_port_pkg::cnt_w-1:0] count;
  logic [sram_port_pkg::cnt_w-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != sram_port_pkg::cnt_zero) begin
      next_count = count - sram_port_pkg::cnt_one;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= sram_port_pkg::cnt_zero;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == sram_port_pkg::cnt_zero) && !load;
endmodule

// ===== sram_host_ctrl.sv
// Controller that drives an asynchronous 128K x 16 static memory by its pins.
// Assumes the memory shares clk-free pins; read data is sampled synchronously.
// Contract
// (R1) Wait 1 us after power before access
// (R2) Write happens while select, strobe, lane low
// (R3) Write ends on first strobe/select/lane rise
// (R4) Address stable before and after write strobe
// (R5) Lane enable held low before write end
// (R6) Write data set up, held past end
// (R7) Strobe-ended write with output enable stretched
// (R8) Read data valid after address access delay
// (R9) Old data held briefly after address change
// (R10) Data valid after select falls
// (R11) Data valid after output enable falls
// (R12) Lane data valid after lane enable falls
// (R13) Lane released after lane enable rises
// (R14) Memory powers down after select rises
// (R15) Data pins float when output or lanes off
// (R16) Joint select/strobe rise keeps outputs floating
// (R17) Write strobe high throughout every read
// (R18) Address valid by select falling edge
// (R19) Memory turns outputs off faster than on
// (R20) Read drives only enabled lanes
// (R21) Write stores only enabled lanes
// (R22) 17-bit address, 16-bit data, two lanes
`timescale 1ns/1ps
module sram_host_ctrl #(
  parameter int powerup_cycles = sram_port_pkg::powerup_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire sram_port_pkg::mem_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [sram_port_pkg::data_w-1:0] rsp_data,
  output logic [sram_port_pkg::addr_w-1:0] mem_addr,
  output sram_port_pkg::mem_ctl_t mem_ctl,
  input wire logic [sram_port_pkg::data_w-1:0] mem_data_in,
  output logic [sram_port_pkg::data_w-1:0] mem_data_out,
  output logic mem_data_oe
);
  typedef enum logic [2:0] {st_power, st_idle, st_read, st_write, st_release} state_t;

  state_t state;
  state_t next_state;
  logic [31:0] power_count;
  logic [31:0] next_power_count;
  logic next_req_ready;
  logic next_rsp_valid;
  logic [sram_port_pkg::data_w-1:0] next_rsp_data;
  logic [sram_port_pkg::addr_w-1:0] next_mem_addr;
  sram_port_pkg::mem_ctl_t next_mem_ctl;
  logic [sram_port_pkg::data_w-1:0] next_mem_data_out;
  logic next_mem_data_oe;
  logic [1:0] lanes;
  logic [1:0] next_lanes;
  logic timer_load;
  logic [sram_port_pkg::cnt_w-1:0] timer_value;
  logic timer_done;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  sram_cycle_timer timer (
    .clk(clk),
    .rst(rst),
    .load(timer_load),
    .load_value(timer_value),
    .done(timer_done)
  );

  // Keep only bytes whose lane enable was low
  function automatic logic [sram_port_pkg::data_w-1:0] lane_mask(
    input logic [sram_port_pkg::data_w-1:0] d, input logic [1:0] en);
    lane_mask = {en[1] ? d[sram_port_pkg::data_w-1:sram_port_pkg::lane_w]
                       : 8'h00,
                 en[0] ? d[sram_port_pkg::lane_w-1:0] : 8'h00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power-up wait counter, stops at its ceiling
  always_comb begin
    next_power_count = power_count;
    if (power_count < 32'(powerup_cycles)) begin // [R1]
      next_power_count = power_count + 32'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_count <= 32'h0000_0000;
    end else begin
      power_count <= next_power_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  assign take = (state == st_idle) && req_valid && req_ready;

  always_comb begin
    next_state = state;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_lanes = lanes;
    timer_load = 1'b0;
    timer_value = sram_port_pkg::cnt_zero;
    case (state)
      st_power: begin
        if (power_count >= 32'(powerup_cycles)) begin // [R1]
          next_state = st_idle;
          next_req_ready = 1'b1;
        end
      end
      st_idle: begin
        next_req_ready = 1'b1;
        if (take) begin
          next_req_ready = 1'b0;
          next_lanes = req.lanes;
          timer_load = 1'b1;
          if (req.write) begin
            timer_value = sram_port_pkg::cnt_w'(sram_port_pkg::write_cycles);
            next_state = st_write;
          end else begin
            timer_value = sram_port_pkg::cnt_w'(sram_port_pkg::read_cycles);
            next_state = st_read;
          end
        end
      end
      st_read: begin
        if (timer_done) begin // [R8] [R10] [R11] [R12]
          next_rsp_data = lane_mask(mem_data_in, lanes);
          next_rsp_valid = 1'b1;
          next_state = st_release;
        end
      end
      st_write: begin
        if (timer_done) begin
          next_rsp_valid = 1'b1;
          next_state = st_release;
        end
      end
      st_release: begin
        next_req_ready = 1'b1;
        next_state = st_idle;
      end
      default: begin
        next_state = st_power;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_power;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      lanes <= 2'h0;
    end else begin
      state <= next_state;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      lanes <= next_lanes;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory pins
  always_comb begin
    next_mem_addr = mem_addr;
    next_mem_ctl = mem_ctl;
    next_mem_data_out = mem_data_out;
    next_mem_data_oe = mem_data_oe;
    case (state)
      st_idle: begin
        if (take) begin
          // Address set with select, never after it [R18] [R4] [R22]
          next_mem_addr = req.addr;
          next_mem_ctl.chip_select_n = 1'b0;
          next_mem_ctl.low_lane_enable_n = !req.lanes[0]; // [R20] [R21]
          next_mem_ctl.high_lane_enable_n = !req.lanes[1];
          if (req.write) begin
            // Output enable stays high so no turnoff stretch is needed [R7]
            next_mem_ctl.output_enable_n = 1'b1;
            next_mem_ctl.write_strobe_n = 1'b0; // [R2]
            next_mem_data_out = req.wdata; // [R6]
            next_mem_data_oe = 1'b1;
          end else begin
            next_mem_ctl.output_enable_n = 1'b0;
            next_mem_ctl.write_strobe_n = 1'b1; // [R17]
            next_mem_data_oe = 1'b0;
          end
        end
      end
      st_read: begin
        if (timer_done) begin
          next_mem_ctl = sram_port_pkg::ctl_idle; // [R13] [R14] [R15]
        end
      end
      st_write: begin
        if (timer_done) begin
          // Strobe, select and lanes rise together; data and address held [R3] [R5] [R16]
          next_mem_ctl = sram_port_pkg::ctl_idle;
        end
      end
      st_release: begin
        // One idle cycle: data hold after write end, bus turnaround [R6] [R19]
        next_mem_data_oe = 1'b0;
      end
      default: begin
        next_mem_ctl = sram_port_pkg::ctl_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_addr <= 17'h0_0000;
      mem_ctl <= sram_port_pkg::ctl_idle;
      mem_data_out <= 16'h0000;
      mem_data_oe <= 1'b0;
    end else begin
      mem_addr <= next_mem_addr;
      mem_ctl <= next_mem_ctl;
      mem_data_out <= next_mem_data_out;
      mem_data_oe <= next_mem_data_oe;
    end
  end
endmodule

// ===== sram_model.sv
// Behavioural two-lane static memory, zero delay.
// Assumes controller pins and a resolved data bus.
`timescale 1ns/1ps
module sram_model (
  input wire logic [16:0] addr,
  input wire sram_port_pkg::mem_ctl_t ctl,
  input wire logic [15:0] bus,
  output logic [15:0] dout
);
  logic [15:0] mem [0:131071];
  logic [15:0] m, wd;
  logic [16:0] wa;
  logic [1:0] wl, le;
  logic rd, wend;
  assign le = ~{ctl.high_lane_enable_n, ctl.low_lane_enable_n};
  assign rd = !ctl.chip_select_n && !ctl.output_enable_n && ctl.write_strobe_n;
  assign wend = ctl.chip_select_n || ctl.write_strobe_n || le == 2'b00;
  always @* begin
    if (!wend) begin
      wa = addr;
      wd = bus;
      wl = le;
    end
  end
  always @(posedge wend) begin
    if (wl[0]) mem[wa][7:0] = wd[7:0];
    if (wl[1]) mem[wa][15:8] = wd[15:8];
  end
  assign m = mem[addr];
  // Floating lanes show the inverse value
  assign dout[7:0] = rd && le[0] ? m[7:0] : ~m[7:0];
  assign dout[15:8] = rd && le[1] ? m[15:8] : ~m[15:8];
endmodule

// ===== sram_host_ctrl_chk.sv
// Pin sequencing checks for the memory controller.
// Assumes binding onto sram_host_ctrl; one clock.
`timescale 1ns/1ps
module sram_host_ctrl_chk #(
  parameter int powerup_cycles = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [16:0] mem_addr,
  input wire sram_port_pkg::mem_ctl_t mem_ctl,
  input wire logic [15:0] mem_data_out,
  input wire logic mem_data_oe
);
  logic [7:0] up;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up <= 8'h00;
    else if (up != 8'hFF) up <= up + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_s;
    !mem_ctl.output_enable_n [*2] ##1 rsp_valid && mem_ctl == sram_port_pkg::ctl_idle;
  endsequence
  sequence wr_s;
    !mem_ctl.write_strobe_n [*2] ##1 rsp_valid && mem_ctl == 5'h1F && mem_data_oe
      ##1 !mem_data_oe;
  endsequence
  power_wait_a: assert property (req_ready |-> up > powerup_cycles)
    else $error("ready too early");
  take_req_a: assert property (req_valid && req_ready |=> !mem_ctl.chip_select_n && !req_ready)
    else $error("request not issued");
  read_seq_a: assert property ($fell(mem_ctl.output_enable_n) |-> rd_s)
    else $error("read sequence wrong");
  write_seq_a: assert property ($fell(mem_ctl.write_strobe_n) |-> wr_s)
    else $error("write sequence wrong");
  read_strobe_a: assert property (!mem_ctl.output_enable_n |-> mem_ctl.write_strobe_n)
    else $error("strobe low in read");
  write_drive_a: assert property (!mem_ctl.write_strobe_n |-> mem_data_oe && !mem_ctl.chip_select_n)
    else $error("write without drive");
  addr_hold_a: assert property (!mem_ctl.chip_select_n && $past(!mem_ctl.chip_select_n)
    |-> $stable({mem_addr, mem_ctl})) else $error("address moved");
  data_hold_a: assert property (mem_data_oe && $past(mem_data_oe) |-> $stable(mem_data_out))
    else $error("data moved");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("response not a pulse");
endmodule
bind sram_host_ctrl sram_host_ctrl_chk #(.powerup_cycles(powerup_cycles)) i_chk (
  .clk(clk),
  .rst(rst),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .rsp_valid(rsp_valid),
  .mem_addr(mem_addr),
  .mem_ctl(mem_ctl),
  .mem_data_out(mem_data_out),
  .mem_data_oe(mem_data_oe)
);

// ===== sram_host_ctrl_bench.sv
// Bench: controller against the behavioural memory.
// Assumes a power-up wait shortened to 4 cycles.
`timescale 1ns/1ps
module sram_host_ctrl_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  sram_port_pkg::mem_req_t req = '0;
  logic req_ready, rsp_valid, mem_data_oe;
  logic [15:0] rsp_data, mem_data_out, mdo, bus;
  logic [16:0] mem_addr, a, e;
  sram_port_pkg::mem_ctl_t mem_ctl;
  logic [15:0] rm [logic [16:0]];
  logic [16:0] q [$];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 52527;
  always #20 clk = ~clk;
  assign bus = mem_data_oe ? mem_data_out : mdo;
  sram_host_ctrl #(.powerup_cycles(4)) i_sram_host_ctrl (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .mem_addr(mem_addr), .mem_ctl(mem_ctl), .mem_data_in(bus),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
  sram_model i_sram_model (.addr(mem_addr), .ctl(mem_ctl), .bus(bus), .dout(mdo));
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task acc(input logic w, input logic [1:0] ln, input logic [16:0] ad, input logic [15:0] d);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    if (w) rm[ad] = (rm[ad] & ~m) | (d & m);
    q.push_back({!w, rm[ad] & m});
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{w, ln, ad, d};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      e = q.pop_front();
      if (e[16]) chk("rsp_data", rsp_data, e[15:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    chk("reset_pins", {10'h0, req_ready, mem_ctl}, {11'h0, sram_port_pkg::ctl_idle});
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = 17'($random(seed));
      acc(1'b1, 2'b11, a, 16'($random(seed)));
      for (int l = 0; l < 4; l++) begin
        acc(1'b1, 2'(l), a, 16'($random(seed)));
        acc(1'b0, 2'b11, a, 16'h0000);
        acc(1'b0, 2'(l), a, 16'h0000);
      end
      $display("test %0d done", i);
    end
    repeat (8) @(posedge clk);
    tally_and_finish();
  end
endmodule
